// ---- hpt_pkg.sv ----
// package of constants for the host port and tdm stream pins block,
// plus the small memory that holds the interrupt channel queue.
// assumes one core clock and a separate serial bit clock from the backplane.
package hpt_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CHAN_N = 32;
	localparam int CHAN_W = 5;
	localparam int PTR_W = 6;
	localparam int HCNT_W = 9;
	localparam int RUN_W = 4;
	localparam logic [12:0] MAIN_CTRL_ADDR = 13'h0000;
	localparam logic [12:0] IRQ_FIFO_ADDR = 13'h0001;
	localparam int ODE_BIT = 6;
	localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int FIFO_VALID_BIT = 7;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;
	localparam logic [4:0] OUT_LEAD = 5'h02;
	localparam logic [3:0] IDLE_RUN = 4'hF;
	localparam real CORE_CLK_MHZ = 250.0;
	localparam real BIT_CLK_MHZ = 4.096;
	localparam real STREAM_MBPS = 2.048;
	localparam int HALVES_PER_BIT = 2;
	typedef enum logic [3:0]
	{
		HPT_IDLE = 4'h1,
		HPT_FETCH = 4'h2,
		HPT_DRIVE = 4'h4,
		HPT_ACK = 4'h8
	} hpt_hstate_t;
endpackage : hpt_pkg

`timescale 1ns/1ps
module hpt_ram
(
	input wire logic clk,
	input wire logic we,
	input wire logic [hpt_pkg::CHAN_W-1:0] waddr,
	input wire logic [hpt_pkg::CHAN_W-1:0] wdata,
	input wire logic [hpt_pkg::CHAN_W-1:0] raddr,
	output logic [hpt_pkg::CHAN_W-1:0] rdata
);
	logic [hpt_pkg::CHAN_W-1:0] mem [hpt_pkg::CHAN_N];

	// write port and registered read port
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : hpt_ram

// ---- hpt_top.sv ----
// host microprocessor port and tdm serial stream pins.
// assumes host pins are asynchronous to core_clk and stream pins are
// timed by serial_bit_clock; open-drain and two-way pins are resolved outside.
//
// Overview of operation
// R1 - interrupt line pulled low when any channel raises an interrupt
// R2 - interrupt line released only after every queued entry is read out
// R3 - access starts only with data strobe and chip select both low
// R4 - with chip select high the port ignores all bus activity
// R5 - read/write selects direction: device drives on reads, samples on writes
// R6 - transfer acknowledge pulled low when the transfer is completed
// R7 - host data bus is eight bits wide and two-way
// R8 - serial outputs enabled only when drive-enable pin and control bit six high
// R9 - either enable low puts both serial outputs in high impedance
// R10 - send output carries port 1 stream, 32 byte slots per frame
// R11 - receive output carries port 2 stream, 32 slots per frame
// R12 - send input accepts port 2 stream, 32 slots per frame
// R13 - receive input accepts port 1 stream, 32 slots per frame
// R14 - stream bits use the 4.096 MHz serial clock, two clocks per bit
// R15 - frame sync polarity detected automatically, low or high pulse format
// R16 - host holds the 13-bit address stable during the whole strobe
`timescale 1ns/1ps
module hpt_top
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic chip_select_n,
	input wire logic data_strobe_n,
	input wire logic read_write,
	input wire logic [hpt_pkg::ADDR_W-1:0] host_addr_bus,
	input wire logic [hpt_pkg::DATA_W-1:0] host_data_bus_in,
	output logic [hpt_pkg::DATA_W-1:0] host_data_bus_out,
	output logic host_data_bus_oe_n,
	input wire logic transfer_ack_n_in,
	output logic transfer_ack_n_out,
	output logic transfer_ack_n_oe_n,
	input wire logic irq_n_in,
	output logic irq_n_out,
	output logic irq_n_oe_n,
	input wire logic [hpt_pkg::CHAN_N-1:0] chan_irq_event,
	output logic [hpt_pkg::DATA_W-1:0] main_ctrl,
	output logic frame_format_gci,
	output logic slot_valid,
	output logic [hpt_pkg::CHAN_W-1:0] slot_chan,
	output logic [hpt_pkg::DATA_W-1:0] slot_send_in_byte,
	output logic [hpt_pkg::DATA_W-1:0] slot_recv_in_byte,
	output logic [hpt_pkg::CHAN_W-1:0] slot_out_chan,
	input wire logic [hpt_pkg::DATA_W-1:0] slot_send_out_byte,
	input wire logic [hpt_pkg::DATA_W-1:0] slot_recv_out_byte,
	input wire logic serial_bit_clock,
	input wire logic frame_sync_in,
	input wire logic output_drive_enable,
	input wire logic send_in,
	input wire logic recv_in,
	output logic send_out,
	output logic send_out_oe_n,
	output logic recv_out,
	output logic recv_out_oe_n
);
	typedef struct packed
	{
		hpt_pkg::hpt_hstate_t state;
		logic cs_s1;
		logic cs_s2;
		logic ds_s1;
		logic ds_s2;
		logic rw_s1;
		logic rw_s2;
		logic [hpt_pkg::ADDR_W-1:0] addr_s1;
		logic [hpt_pkg::ADDR_W-1:0] addr_s2;
		logic [hpt_pkg::DATA_W-1:0] din_s1;
		logic [hpt_pkg::DATA_W-1:0] din_s2;
		logic [hpt_pkg::ADDR_W-1:0] addr_hold;
		logic [hpt_pkg::DATA_W-1:0] main_ctrl;
		logic [hpt_pkg::DATA_W-1:0] dout;
		logic dout_oe_n;
		logic ack_oe_n;
		logic irq_oe_n;
		logic pin_low;
		logic [hpt_pkg::CHAN_N-1:0] req;
		logic [hpt_pkg::CHAN_N-1:0] queued;
		logic [hpt_pkg::PTR_W-1:0] wr_ptr;
		logic [hpt_pkg::PTR_W-1:0] rd_ptr;
		logic lreq_s1;
		logic lreq_s2;
		logic lreq_s3;
		logic ack_tgl;
		logic [hpt_pkg::DATA_W-1:0] tx_send;
		logic [hpt_pkg::DATA_W-1:0] tx_recv;
		logic slot_valid;
		logic [hpt_pkg::CHAN_W-1:0] slot_chan;
		logic [hpt_pkg::CHAN_W-1:0] slot_out_chan;
		logic [hpt_pkg::DATA_W-1:0] slot_si;
		logic [hpt_pkg::DATA_W-1:0] slot_ri;
		logic gci_s1;
		logic gci_s2;
	} hpt_core_t;

	typedef struct packed
	{
		logic fs_q;
		logic fs_prev;
		logic act_prev;
		logic [hpt_pkg::RUN_W-1:0] run;
		logic fmt_known;
		logic fmt_gci;
		logic running;
		logic [hpt_pkg::HCNT_W-1:0] hcnt;
		logic [hpt_pkg::DATA_W-1:0] sh_si;
		logic [hpt_pkg::DATA_W-1:0] sh_ri;
		logic [hpt_pkg::DATA_W-1:0] sh_so;
		logic [hpt_pkg::DATA_W-1:0] sh_ro;
		logic so;
		logic ro;
		logic so_oe_n;
		logic ro_oe_n;
		logic ode_s1;
		logic ode_s2;
		logic en_s1;
		logic en_s2;
		logic req_tgl;
		logic [hpt_pkg::CHAN_W-1:0] cap_chan;
		logic [hpt_pkg::DATA_W-1:0] cap_si;
		logic [hpt_pkg::DATA_W-1:0] cap_ri;
		logic ack_s1;
		logic ack_s2;
	} hpt_link_t;

	hpt_core_t st;
	hpt_core_t next_st;
	hpt_link_t lk;
	hpt_link_t next_lk;
	logic lrst_meta;
	logic lrst;
	logic ram_we;
	logic [hpt_pkg::CHAN_W-1:0] ram_wdata;
	logic [hpt_pkg::CHAN_W-1:0] ram_rdata;

	// lowest pending channel not already in the queue
	function automatic logic [hpt_pkg::CHAN_W:0] hpt_pick(input logic [hpt_pkg::CHAN_N-1:0] v);
		logic [hpt_pkg::CHAN_W:0] r;
		r = '0;
		for (int i = hpt_pkg::CHAN_N - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = {1'b1, i[hpt_pkg::CHAN_W-1:0]};
			end
		end
		return r;
	endfunction : hpt_pick

	hpt_ram u_queue
	(
		.clk(core_clk),
		.we(ram_we),
		.waddr(st.wr_ptr[hpt_pkg::CHAN_W-1:0]),
		.wdata(ram_wdata),
		.raddr(st.rd_ptr[hpt_pkg::CHAN_W-1:0]),
		.rdata(ram_rdata)
	);

	// core domain: host port, interrupt queue, slot exchange
	always_comb
	begin
		logic [hpt_pkg::CHAN_W:0] pick;
		logic [hpt_pkg::CHAN_N-1:0] enq;
		logic [hpt_pkg::CHAN_N-1:0] pop;
		logic strobe;
		logic fifo_empty;
		pick = '0;
		enq = '0;
		pop = '0;
		strobe = 1'b0;
		fifo_empty = 1'b0;
		next_st = st;
		ram_we = 1'b0;
		ram_wdata = '0;
		next_st.cs_s1 = chip_select_n;
		next_st.cs_s2 = st.cs_s1;
		next_st.ds_s1 = data_strobe_n;
		next_st.ds_s2 = st.ds_s1;
		next_st.rw_s1 = read_write;
		next_st.rw_s2 = st.rw_s1;
		next_st.addr_s1 = host_addr_bus;
		next_st.addr_s2 = st.addr_s1;
		next_st.din_s1 = host_data_bus_in;
		next_st.din_s2 = st.din_s1;
		next_st.gci_s1 = lk.fmt_gci;
		next_st.gci_s2 = st.gci_s1;
		next_st.lreq_s1 = lk.req_tgl;
		next_st.lreq_s2 = st.lreq_s1;
		next_st.lreq_s3 = st.lreq_s2;
		strobe = !st.cs_s2 && !st.ds_s2; // [R3] [R4]
		fifo_empty = (st.wr_ptr == st.rd_ptr);
		case (st.state)
			hpt_pkg::HPT_IDLE:
			begin
				if (strobe)
				begin
					next_st.addr_hold = st.addr_s2; // [R16]
					if (st.rw_s2)
					begin
						next_st.state = hpt_pkg::HPT_FETCH;
					end
					else
					begin
						if (st.addr_s2 == hpt_pkg::MAIN_CTRL_ADDR)
						begin
							next_st.main_ctrl = st.din_s2; // [R5] [R7]
						end
						next_st.ack_oe_n = 1'b0; // [R6]
						next_st.state = hpt_pkg::HPT_ACK;
					end
				end
			end
			hpt_pkg::HPT_FETCH:
			begin
				next_st.dout = hpt_pkg::ZERO_BYTE;
				if (st.addr_hold == hpt_pkg::MAIN_CTRL_ADDR)
				begin
					next_st.dout = st.main_ctrl;
				end
				else if (st.addr_hold == hpt_pkg::IRQ_FIFO_ADDR && !fifo_empty)
				begin
					next_st.dout[hpt_pkg::FIFO_VALID_BIT] = 1'b1;
					next_st.dout[hpt_pkg::CHAN_W-1:0] = ram_rdata;
					pop[ram_rdata] = 1'b1; // [R2]
					next_st.rd_ptr = st.rd_ptr + 1'b1;
				end
				next_st.dout_oe_n = 1'b0; // [R5] [R7]
				next_st.state = hpt_pkg::HPT_DRIVE;
			end
			hpt_pkg::HPT_DRIVE:
			begin
				next_st.ack_oe_n = 1'b0; // [R6]
				next_st.state = hpt_pkg::HPT_ACK;
			end
			hpt_pkg::HPT_ACK:
			begin
				if (!strobe)
				begin
					next_st.ack_oe_n = 1'b1;
					next_st.dout_oe_n = 1'b1;
					next_st.state = hpt_pkg::HPT_IDLE;
				end
			end
			default:
			begin
				next_st.ack_oe_n = 1'b1;
				next_st.dout_oe_n = 1'b1;
				next_st.state = hpt_pkg::HPT_IDLE;
			end
		endcase
		pick = hpt_pick(st.req & ~st.queued);
		if (pick[hpt_pkg::CHAN_W])
		begin
			enq[pick[hpt_pkg::CHAN_W-1:0]] = 1'b1;
			ram_we = 1'b1;
			ram_wdata = pick[hpt_pkg::CHAN_W-1:0];
			next_st.wr_ptr = st.wr_ptr + 1'b1;
		end
		// new events win over the clear of the same channel
		next_st.req = (st.req & ~enq) | chan_irq_event; // [R1]
		next_st.queued = (st.queued | enq) & ~pop;
		next_st.irq_oe_n = (next_st.wr_ptr == next_st.rd_ptr); // [R1] [R2]
		next_st.slot_valid = 1'b0;
		if (st.lreq_s2 != st.lreq_s3)
		begin
			next_st.slot_valid = 1'b1; // [R12] [R13]
			next_st.slot_chan = lk.cap_chan;
			next_st.slot_out_chan = lk.cap_chan + hpt_pkg::OUT_LEAD;
			next_st.slot_si = lk.cap_si;
			next_st.slot_ri = lk.cap_ri;
		end
		if (st.slot_valid)
		begin
			next_st.tx_send = slot_send_out_byte; // [R10]
			next_st.tx_recv = slot_recv_out_byte; // [R11]
			next_st.ack_tgl = !st.ack_tgl;
		end
		if (sys_rst)
		begin
			next_st = '0;
			next_st.state = hpt_pkg::HPT_IDLE;
			next_st.cs_s1 = 1'b1;
			next_st.cs_s2 = 1'b1;
			next_st.ds_s1 = 1'b1;
			next_st.ds_s2 = 1'b1;
			next_st.main_ctrl = hpt_pkg::MAIN_CTRL_RST;
			next_st.dout_oe_n = 1'b1;
			next_st.ack_oe_n = 1'b1;
			next_st.irq_oe_n = 1'b1;
			ram_we = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		st <= next_st;
	end

	// link domain reset
	always_ff @(posedge serial_bit_clock)
	begin
		lrst_meta <= sys_rst;
		lrst <= lrst_meta;
	end

	// link domain: frame detection, serial shifting, output enables
	always_comb
	begin
		logic act;
		logic [2:0] bitpos;
		logic [hpt_pkg::DATA_W-1:0] load_s;
		logic [hpt_pkg::DATA_W-1:0] load_r;
		act = 1'b0;
		bitpos = '0;
		load_s = '0;
		load_r = '0;
		next_lk = lk;
		next_lk.fs_q = frame_sync_in;
		next_lk.fs_prev = lk.fs_q;
		next_lk.ode_s1 = output_drive_enable;
		next_lk.ode_s2 = lk.ode_s1;
		next_lk.en_s1 = st.main_ctrl[hpt_pkg::ODE_BIT];
		next_lk.en_s2 = lk.en_s1;
		next_lk.ack_s1 = st.ack_tgl;
		next_lk.ack_s2 = lk.ack_s1;
		// idle level seen for a long run fixes the pulse polarity
		if (lk.fs_q != lk.fs_prev)
		begin
			next_lk.run = '0;
		end
		else if (lk.run != hpt_pkg::IDLE_RUN)
		begin
			next_lk.run = lk.run + 1'b1;
		end
		else
		begin
			next_lk.fmt_known = 1'b1; // [R15]
			next_lk.fmt_gci = !lk.fs_q;
		end
		act = lk.fmt_gci ? lk.fs_q : !lk.fs_q; // [R15]
		next_lk.act_prev = act;
		next_lk.hcnt = lk.hcnt + 1'b1; // [R14]
		if (act && !lk.act_prev && lk.fmt_known)
		begin
			next_lk.hcnt = '0;
			next_lk.running = 1'b1;
		end
		bitpos = lk.hcnt[3:1];
		if (lk.running)
		begin
			if (lk.hcnt[0])
			begin
				next_lk.sh_si = {lk.sh_si[hpt_pkg::DATA_W-2:0], send_in}; // [R12] [R14]
				next_lk.sh_ri = {lk.sh_ri[hpt_pkg::DATA_W-2:0], recv_in}; // [R13]
				if (bitpos == hpt_pkg::LAST_BIT)
				begin
					next_lk.cap_si = next_lk.sh_si;
					next_lk.cap_ri = next_lk.sh_ri;
					next_lk.cap_chan = lk.hcnt[hpt_pkg::HCNT_W-1:4];
					next_lk.req_tgl = !lk.req_tgl;
				end
			end
			else if (bitpos == hpt_pkg::FIRST_BIT)
			begin
				load_s = hpt_pkg::IDLE_BYTE;
				load_r = hpt_pkg::IDLE_BYTE;
				// the toggle of the slot just ended is one clock old here; the bytes
				// for this slot came from the handshake before it
				if (lk.ack_s2 != lk.req_tgl) // [R10] [R11]
				begin
					load_s = st.tx_send;
					load_r = st.tx_recv;
				end
				next_lk.so = load_s[hpt_pkg::DATA_W-1]; // [R10]
				next_lk.ro = load_r[hpt_pkg::DATA_W-1]; // [R11]
				next_lk.sh_so = {load_s[hpt_pkg::DATA_W-2:0], 1'b1};
				next_lk.sh_ro = {load_r[hpt_pkg::DATA_W-2:0], 1'b1};
			end
			else
			begin
				next_lk.so = lk.sh_so[hpt_pkg::DATA_W-1]; // [R10] [R14]
				next_lk.ro = lk.sh_ro[hpt_pkg::DATA_W-1]; // [R11]
				next_lk.sh_so = {lk.sh_so[hpt_pkg::DATA_W-2:0], 1'b1};
				next_lk.sh_ro = {lk.sh_ro[hpt_pkg::DATA_W-2:0], 1'b1};
			end
		end
		next_lk.so_oe_n = !(lk.ode_s2 && lk.en_s2); // [R8] [R9]
		next_lk.ro_oe_n = !(lk.ode_s2 && lk.en_s2); // [R8] [R9]
		if (lrst)
		begin
			next_lk = '0;
			next_lk.so = 1'b1;
			next_lk.ro = 1'b1;
			next_lk.so_oe_n = 1'b1;
			next_lk.ro_oe_n = 1'b1;
		end
	end

	always_ff @(posedge serial_bit_clock)
	begin
		lk <= next_lk;
	end

	assign host_data_bus_out = st.dout;
	assign host_data_bus_oe_n = st.dout_oe_n;
	assign transfer_ack_n_out = st.pin_low;
	assign transfer_ack_n_oe_n = st.ack_oe_n;
	assign irq_n_out = st.pin_low;
	assign irq_n_oe_n = st.irq_oe_n;
	assign main_ctrl = st.main_ctrl;
	assign frame_format_gci = st.gci_s2;
	assign slot_valid = st.slot_valid;
	assign slot_chan = st.slot_chan;
	assign slot_out_chan = st.slot_out_chan;
	assign slot_send_in_byte = st.slot_si;
	assign slot_recv_in_byte = st.slot_ri;
	assign send_out = lk.so;
	assign send_out_oe_n = lk.so_oe_n;
	assign recv_out = lk.ro;
	assign recv_out_oe_n = lk.ro_oe_n;
endmodule : hpt_top

// ---- hpt_checker.sv ----
// assertions on the host port and stream pins
// assumes binding into hpt_top
`timescale 1ns/1ps
module hpt_checker
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic chip_select_n,
	input wire logic data_strobe_n,
	input wire logic read_write,
	input wire logic host_data_bus_oe_n,
	input wire logic transfer_ack_n_oe_n,
	input wire logic irq_n_oe_n,
	input wire logic [31:0] chan_irq_event,
	input wire logic [7:0] main_ctrl,
	input wire logic slot_valid,
	input wire logic [4:0] slot_chan,
	input wire logic [4:0] slot_out_chan,
	input wire logic serial_bit_clock,
	input wire logic output_drive_enable,
	input wire logic send_out_oe_n,
	input wire logic recv_out_oe_n
);
	a_ack_needs_both: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(transfer_ack_n_oe_n) |-> $past(!chip_select_n, 2) && $past(!data_strobe_n, 2)) else $error("ack no access");
	a_cs_high_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
		chip_select_n [*5] |-> transfer_ack_n_oe_n && host_data_bus_oe_n) else $error("deselected port active");
	a_read_drives: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(host_data_bus_oe_n) |-> $past(read_write, 2)) else $error("drive without read");
	a_write_no_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
		!read_write [*5] |-> host_data_bus_oe_n) else $error("drive during write");
	a_release_together: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(host_data_bus_oe_n) |-> $rose(transfer_ack_n_oe_n)) else $error("data and ack split");
	a_irq_follows_event: assert property (@(posedge core_clk) disable iff (sys_rst)
		|chan_irq_event |-> ##[2:3] !irq_n_oe_n) else $error("irq not raised");
	a_slot_two_ahead: assert property (@(posedge core_clk) disable iff (sys_rst)
		slot_valid |-> slot_out_chan == slot_chan + 5'h02) else $error("out slot offset");
	a_slot_one_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
		slot_valid |=> !slot_valid) else $error("slot pulse long");
	a_pin_gates_out: assert property (@(posedge serial_bit_clock) disable iff (sys_rst)
		!output_drive_enable [*5] |-> send_out_oe_n && recv_out_oe_n) else $error("pin gate");
	a_bit_gates_out: assert property (@(posedge serial_bit_clock) disable iff (sys_rst)
		!main_ctrl[hpt_pkg::ODE_BIT] [*5] |-> send_out_oe_n && recv_out_oe_n) else $error("bit gate");
	a_outs_paired: assert property (@(posedge serial_bit_clock) disable iff (sys_rst)
		send_out_oe_n == recv_out_oe_n) else $error("outputs split");
	c_ack: cover property (@(posedge core_clk) $fell(transfer_ack_n_oe_n));
	c_slot: cover property (@(posedge core_clk) slot_valid);
	c_out_on: cover property (@(posedge serial_bit_clock) !send_out_oe_n);
endmodule : hpt_checker

bind hpt_top hpt_checker hpt_checker_i (.core_clk, .sys_rst, .chip_select_n, .data_strobe_n, .read_write,
	.host_data_bus_oe_n, .transfer_ack_n_oe_n, .irq_n_oe_n, .chan_irq_event, .main_ctrl, .slot_valid,
	.slot_chan, .slot_out_chan, .serial_bit_clock, .output_drive_enable, .send_out_oe_n, .recv_out_oe_n);

// ---- hpt_backplane.sv ----
// backplane model: link clock, frame pulse, input streams, output capture
// assumes msb first, two link clocks a bit
`timescale 1ns/1ps
module hpt_backplane
(
	input wire logic gci,
	output logic serial_bit_clock,
	output logic frame_sync_in,
	output logic send_in,
	output logic recv_in,
	input wire logic send_out,
	input wire logic send_out_oe_n,
	input wire logic recv_out,
	input wire logic recv_out_oe_n
);
	logic [8:0] hc = 9'h000;
	logic [8:0] w;
	logic [8:0] v;
	logic [7:0] sb;
	logic [7:0] rb;
	logic [7:0] got_send [32];
	logic [7:0] got_recv [32];
	initial
	begin
		serial_bit_clock = 1'b0;
		frame_sync_in = 1'b1;
		send_in = 1'b1;
		recv_in = 1'b1;
		#1.3;
		forever #6 serial_bit_clock = ~serial_bit_clock;
	end
	always @(posedge serial_bit_clock)
	begin
		// device slot count runs two clocks behind hc; output bits two more
		w = hc - 9'h004;
		v = hc - 9'h002;
		sb = {3'h5, v[8:4]};
		rb = {3'h2, v[8:4]};
		hc <= hc + 9'h001;
		frame_sync_in <= (hc == 9'h1FF) ? gci : ~gci;
		send_in <= sb[3'h7 - v[3:1]];
		recv_in <= rb[3'h7 - v[3:1]];
		if (!hc[0])
		begin
			got_send[w[8:4]][3'h7 - w[3:1]] <= send_out_oe_n ? ~send_out : send_out;
			got_recv[w[8:4]][3'h7 - w[3:1]] <= recv_out_oe_n ? ~recv_out : recv_out;
		end
	end
endmodule : hpt_backplane

// ---- hpt_top_tb.sv ----
// self-checking bench for hpt_top
// assumes hpt_pkg, hpt_ram, hpt_top, checker and backplane compiled first
`timescale 1ns/1ps
module hpt_top_tb;
	logic core_clk;
	logic sys_rst = 1'b1;
	logic chip_select_n = 1'b1;
	logic data_strobe_n = 1'b1;
	logic read_write = 1'b1;
	logic output_drive_enable = 1'b0;
	logic gci = 1'b0;
	logic [12:0] host_addr_bus = 13'h0000;
	logic [7:0] hwd = 8'h00;
	logic [7:0] send_ob = 8'h00;
	logic [7:0] recv_ob = 8'h00;
	logic [31:0] chan_irq_event = 32'h00000000;
	logic [1:0] sv_q = 2'h0;
	logic [7:0] host_data_bus_out, main_ctrl, slot_send_in_byte, slot_recv_in_byte;
	logic [4:0] slot_chan, slot_out_chan;
	logic host_data_bus_oe_n, transfer_ack_n_out, transfer_ack_n_oe_n, irq_n_out, irq_n_oe_n;
	logic frame_format_gci, slot_valid, serial_bit_clock, frame_sync_in, send_in, recv_in;
	logic send_out, send_out_oe_n, recv_out, recv_out_oe_n;
	int error_cnt = 0;
	int cmp_count = 0;
	hpt_top hpt_top_i (.core_clk, .sys_rst, .chip_select_n, .data_strobe_n, .read_write, .host_addr_bus,
		.host_data_bus_in(host_data_bus_oe_n ? hwd : host_data_bus_out), .host_data_bus_out, .host_data_bus_oe_n,
		.transfer_ack_n_in(transfer_ack_n_oe_n | transfer_ack_n_out), .transfer_ack_n_out, .transfer_ack_n_oe_n,
		.irq_n_in(irq_n_oe_n | irq_n_out), .irq_n_out, .irq_n_oe_n, .chan_irq_event, .main_ctrl, .frame_format_gci,
		.slot_valid, .slot_chan, .slot_send_in_byte, .slot_recv_in_byte, .slot_out_chan,
		.slot_send_out_byte(send_ob), .slot_recv_out_byte(recv_ob), .serial_bit_clock, .frame_sync_in,
		.output_drive_enable, .send_in, .recv_in, .send_out, .send_out_oe_n, .recv_out, .recv_out_oe_n);
	hpt_backplane hpt_backplane_i (.gci, .serial_bit_clock, .frame_sync_in, .send_in, .recv_in,
		.send_out, .send_out_oe_n, .recv_out, .recv_out_oe_n);
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge core_clk)
	begin
		sv_q <= {sv_q[0], slot_valid};
		if (sv_q[1])
		begin
			send_ob <= {3'h6, slot_out_chan + 5'h01};
			recv_ob <= {3'h1, slot_out_chan + 5'h01};
		end
		if (slot_valid === 1'b1)
		begin
			chk8("send in byte", {3'h5, slot_chan}, slot_send_in_byte);
			chk8("recv in byte", {3'h2, slot_chan}, slot_recv_in_byte);
		end
	end
	task automatic host_cycle(input logic rw, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		read_write <= rw;
		host_addr_bus <= a;
		hwd <= wd;
		chip_select_n <= 1'b0;
		data_strobe_n <= 1'b0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (transfer_ack_n_oe_n !== 1'b0 && n < 40);
		rd = host_data_bus_out;
		chk8("ack seen", 8'h01, {7'h00, n < 40});
		chip_select_n <= 1'b1;
		data_strobe_n <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask : host_cycle
	task automatic t_ctrl();
		logic [7:0] rd;
		host_cycle(1'b0, hpt_pkg::MAIN_CTRL_ADDR, 8'h5A, rd);
		host_cycle(1'b1, hpt_pkg::MAIN_CTRL_ADDR, 8'h00, rd);
		chk8("ctrl read", 8'h5A, rd);
		chk8("ctrl port", 8'h5A, main_ctrl);
		host_cycle(1'b0, 13'h1FFF, 8'hA5, rd);
		chk8("unmapped write", 8'h5A, main_ctrl);
		host_cycle(1'b1, 13'h1FFF, 8'h00, rd);
		chk8("unmapped read", 8'h00, rd);
	endtask : t_ctrl
	task automatic t_ignore();
		for (int i = 0; i < 2; i++)
		begin
			read_write <= 1'b0;
			hwd <= 8'hFF;
			host_addr_bus <= hpt_pkg::MAIN_CTRL_ADDR;
			chip_select_n <= i[0];
			data_strobe_n <= ~i[0];
			repeat (20) @(posedge core_clk);
			chk8("lone strobe ack", 8'h01, {7'h00, transfer_ack_n_oe_n});
			chk8("lone strobe ctrl", 8'h5A, main_ctrl);
			chip_select_n <= 1'b1;
			data_strobe_n <= 1'b1;
			repeat (6) @(posedge core_clk);
		end
	endtask : t_ignore
	task automatic t_irq();
		logic [7:0] rd;
		logic [7:0] ex [4];
		ex = '{8'h83, 8'h91, 8'h9F, 8'h00};
		chan_irq_event <= 32'h00020008;
		@(posedge core_clk);
		chan_irq_event <= 32'h80000000;
		@(posedge core_clk);
		chan_irq_event <= 32'h00000000;
		@(posedge core_clk);
		chk8("irq raised", 8'h00, {7'h00, irq_n_oe_n});
		for (int i = 0; i < 4; i++)
		begin
			host_cycle(1'b1, hpt_pkg::IRQ_FIFO_ADDR, 8'h00, rd);
			chk8("queue entry", ex[i], rd);
			chk8("irq line", {7'h00, i > 1}, {7'h00, irq_n_oe_n});
		end
	endtask : t_irq
	task automatic t_ode();
		logic [7:0] rd;
		for (int i = 0; i < 4; i++)
		begin
			host_cycle(1'b0, hpt_pkg::MAIN_CTRL_ADDR, {1'b0, i[1], 6'h00}, rd);
			output_drive_enable <= i[0];
			repeat (20) @(posedge core_clk);
			chk8("send oe", {7'h00, i != 3}, {7'h00, send_out_oe_n});
			chk8("recv oe", {7'h00, i != 3}, {7'h00, recv_out_oe_n});
		end
	endtask : t_ode
	task automatic t_stream(input logic g);
		repeat (4800) @(posedge core_clk);
		chk8("frame format", {7'h00, g}, {7'h00, frame_format_gci});
		for (int c = 0; c < 32; c++)
		begin
			chk8("send out byte", {3'h6, c[4:0]}, hpt_backplane_i.got_send[c]);
			chk8("recv out byte", {3'h1, c[4:0]}, hpt_backplane_i.got_recv[c]);
		end
	endtask : t_stream
	task automatic t_format();
		logic [7:0] rd;
		sys_rst <= 1'b1;
		gci <= 1'b1;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk8("ctrl reset", hpt_pkg::MAIN_CTRL_RST, main_ctrl);
		host_cycle(1'b0, hpt_pkg::MAIN_CTRL_ADDR, 8'h40, rd);
		t_stream(1'b1);
	endtask : t_format
	initial
	begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk8("ctrl reset", hpt_pkg::MAIN_CTRL_RST, main_ctrl);
		t_ctrl();
		t_ignore();
		t_irq();
		t_ode();
		t_stream(1'b0);
		t_format();
		tally_and_finish();
	end
	initial
	begin
		#150000;
		error_cnt++;
		tally_and_finish();
	end
endmodule : hpt_top_tb
